/* verilog/adpm_pin_mux.v */
// Purpose: Pin function multiplexing and reset strap capture of an audio processor.
// Assumes: Core logic provides memory, byte lane, serial and GPIO function signals.
// Notes: Output enables on two-way pins are active low (low while driving).
`timescale 1ns/10ps
`include "adpm_defs.vh"
module adpm_pin_mux (
  input wire i_clk,
  input wire i_rstn,
  // Strap pins, asynchronous.
  input wire i_pm_sel_pin,
  input wire i_front_pair_pin_in,
  input wire i_surround_pair_pin_in,
  input wire i_center_sub_pin_in,
  input wire i_port_g_pin_in,
  input wire i_host_si_pin,
  input wire i_host_ss_pin,
  // Parallel port pins.
  input wire [31:0] i_pd_pin,
  output reg [31:0] o_pd_pin,
  output reg [31:0] o_pd_oe_n,
  output reg [19:0] o_pa_pin,
  input wire i_cs_pin,
  input wire i_rd_pin,
  input wire i_wr_pin,
  output reg o_cs_pin,
  output reg o_rd_pin,
  output reg o_wr_pin,
  output reg o_strobe_oe_n,
  // Core side, memory path.
  input wire [19:0] i_mem_addr,
  input wire [31:0] i_mem_wdata,
  input wire i_mem_drive,
  input wire i_mem_cs,
  input wire i_mem_rd,
  input wire i_mem_wr,
  output reg [31:0] o_mem_rdata,
  // Core side, host byte lane path.
  input wire [7:0] i_host_byte_lane_tx,
  input wire i_host_byte_lane_drive,
  input wire i_host_ready,
  output reg [7:0] o_host_byte_lane_rx,
  output reg o_host_cmd_sel,
  output reg o_host_err,
  output reg o_host_cs,
  output reg o_host_rd,
  output reg o_host_wr,
  // Serial audio.
  input wire i_serial_master,
  input wire i_out_master,
  input wire i_core_word_sync,
  input wire i_core_serial_clock,
  input wire i_core_out_word_sync,
  input wire i_input_word_sync_pin,
  input wire i_input_serial_clock_pin,
  input wire i_output_word_sync_pin,
  output reg o_input_word_sync_pin,
  output reg o_input_word_sync_oe_n,
  output reg o_input_serial_clock_pin,
  output reg o_input_serial_clock_oe_n,
  output reg o_output_word_sync_pin,
  output reg o_output_word_sync_oe_n,
  output reg o_in_word_sync,
  output reg o_in_serial_clock,
  output reg o_out_word_sync,
  input wire [2:0] i_serial_data_inputs,
  output reg [2:0] o_serial_data_inputs,
  input wire i_front_pair_data,
  input wire i_surround_pair_data,
  input wire i_center_sub_data,
  input wire i_port_g_data,
  input wire i_spdif_tx_data,
  input wire i_spdif_select,
  output reg o_front_pair_out,
  output reg o_surround_pair_out,
  output reg o_center_sub_out,
  output reg o_port_g_or_spdif_out,
  // General purpose pins with dedicated roles.
  input wire i_mute_pin,
  output reg o_mute,
  input wire i_data_request,
  input wire i_io_error,
  output reg o_data_request_out,
  output reg o_io_error_out,
  // Captured straps.
  output reg o_parallel_mode,
  output reg o_two_wire_host_link,
  output reg [5:0] o_two_wire_slave_addr,
  output reg o_serial_clock_polarity
);
  localparam ST_RESET = 2'h0;
  localparam ST_SETTLE = 2'h1;
  localparam ST_CAPTURE = 2'h2;
  localparam ST_RUN = 2'h3;

  wire pm_s;
  wire b_s;
  wire c_s;
  wire d_s;
  wire g_s;
  wire si_s;
  wire ss_s;
  wire cs_s;
  wire rd_s;
  wire wr_s;
  wire ws_s;
  wire sck_s;
  wire ows_s;
  wire mute_s;
  wire [31:0] pd_s;
  wire [2:0] sdi_s;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg pmode;
  reg [31:0] mem_oe_n;

  // Parallel-mode enable mask: byte lane low when driving, RDY always driven.
  function [31:0] par_oe_n;
    input drive;
    begin
      par_oe_n = 32'hffffffff;
      par_oe_n[`ADPM_LANE_HI:`ADPM_LANE_LO] = drive ? 8'h00 : 8'hff;
      par_oe_n[`ADPM_BIT_RDY] = 1'b0;
    end
  endfunction

  adpm_sync2 u_pm (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_pm_sel_pin),
    .o_q(pm_s)
  );
  adpm_sync2 u_b (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_front_pair_pin_in),
    .o_q(b_s)
  );
  adpm_sync2 u_c (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_surround_pair_pin_in),
    .o_q(c_s)
  );
  adpm_sync2 u_d (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_center_sub_pin_in),
    .o_q(d_s)
  );
  adpm_sync2 u_g (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_port_g_pin_in),
    .o_q(g_s)
  );
  adpm_sync2 u_si (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_host_si_pin),
    .o_q(si_s)
  );
  adpm_sync2 u_ss (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_host_ss_pin),
    .o_q(ss_s)
  );
  adpm_sync2 u_cs (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_cs_pin),
    .o_q(cs_s)
  );
  adpm_sync2 u_rd (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_rd_pin),
    .o_q(rd_s)
  );
  adpm_sync2 u_wr (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_wr_pin),
    .o_q(wr_s)
  );
  adpm_sync2 u_ws (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_input_word_sync_pin),
    .o_q(ws_s)
  );
  adpm_sync2 u_sck (.i_clk(i_clk), .i_rstn(i_rstn), .i_d(i_input_serial_clock_pin),
    .o_q(sck_s));
  adpm_sync2 u_ows (.i_clk(i_clk), .i_rstn(i_rstn), .i_d(i_output_word_sync_pin),
    .o_q(ows_s));
  adpm_sync2 u_mute (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_d(i_mute_pin),
    .o_q(mute_s)
  );

  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_pd
      adpm_sync2 u_pd (.i_clk(i_clk), .i_rstn(i_rstn), .i_d(i_pd_pin[gi]), .o_q(pd_s[gi]));
    end
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sdi
      adpm_sync2 u_sdi (.i_clk(i_clk), .i_rstn(i_rstn), .i_d(i_serial_data_inputs[gi]),
        .o_q(sdi_s[gi]));
    end
  endgenerate

  // A release tracker lets the strap synchronisers fill for two edges, since
  // they are cleared by reset, then captures the straps and enters run.
  always @* begin
    case (state_r)
      ST_RESET: state_nxt = ST_SETTLE;
      ST_SETTLE: state_nxt = ST_CAPTURE;
      ST_CAPTURE: state_nxt = ST_RUN;
      ST_RUN: state_nxt = ST_RUN;
      default: state_nxt = ST_RESET;
    endcase
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Strap pins settle through the synchronisers during the first two cycles
  // after release; the third edge latches them and they stay frozen.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_parallel_mode <= 1'b0;
      o_two_wire_host_link <= 1'b0;
      o_two_wire_slave_addr <= `ADPM_ADDR_RST;
      o_serial_clock_polarity <= 1'b0;
    end else if (state_r == ST_CAPTURE) begin
      o_parallel_mode <= pm_s;
      o_two_wire_host_link <= b_s;
      o_two_wire_slave_addr <= {si_s, ss_s, 2'b00, d_s, c_s};
      o_serial_clock_polarity <= g_s;
    end
  end

  always @* begin
    pmode = o_parallel_mode & (state_r == ST_RUN);
    mem_oe_n = i_mem_drive ? 32'h00000000 : 32'hffffffff;
  end

  // Parallel port multiplexing.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pd_pin <= 32'h00000000;
      o_pd_oe_n <= 32'hffffffff;
      o_pa_pin <= 20'h00000;
      o_cs_pin <= 1'b1;
      o_rd_pin <= 1'b1;
      o_wr_pin <= 1'b1;
      o_strobe_oe_n <= 1'b1;
      o_mem_rdata <= 32'h00000000;
      o_host_byte_lane_rx <= 8'h00;
      o_host_cmd_sel <= 1'b0;
      o_host_err <= 1'b0;
      o_host_cs <= 1'b1;
      o_host_rd <= 1'b1;
      o_host_wr <= 1'b1;
    end else if (state_r != ST_RUN) begin
      o_pd_oe_n <= 32'hffffffff;
      o_strobe_oe_n <= 1'b1;
    end else if (pmode) begin
      o_pa_pin <= 20'h00000;
      o_pd_pin <= 32'h00000000;
      o_pd_pin[`ADPM_LANE_HI:`ADPM_LANE_LO] <= i_host_byte_lane_tx;
      o_pd_pin[`ADPM_BIT_RDY] <= i_host_ready;
      o_pd_oe_n <= par_oe_n(i_host_byte_lane_drive);
      o_strobe_oe_n <= 1'b1;
      o_host_byte_lane_rx <= pd_s[`ADPM_LANE_HI:`ADPM_LANE_LO];
      o_host_cmd_sel <= pd_s[`ADPM_BIT_CD];
      o_host_err <= pd_s[`ADPM_BIT_ERR];
      o_host_cs <= cs_s;
      o_host_rd <= rd_s;
      o_host_wr <= wr_s;
      o_mem_rdata <= 32'h00000000;
    end else begin
      o_pa_pin <= i_mem_addr;
      o_pd_pin <= i_mem_wdata;
      o_pd_oe_n <= mem_oe_n;
      o_cs_pin <= i_mem_cs;
      o_rd_pin <= i_mem_rd;
      o_wr_pin <= i_mem_wr;
      o_strobe_oe_n <= 1'b0;
      o_mem_rdata <= pd_s;
      o_host_byte_lane_rx <= 8'h00;
      o_host_cmd_sel <= 1'b0;
      o_host_err <= 1'b0;
      o_host_cs <= 1'b1;
      o_host_rd <= 1'b1;
      o_host_wr <= 1'b1;
    end
  end

  // Serial audio pins. The audio clock domain itself sits upstream; this
  // block only routes its signals, so rates do not depend on i_clk.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_input_word_sync_pin <= `ADPM_SYNC_RST;
      o_input_word_sync_oe_n <= 1'b1;
      o_input_serial_clock_pin <= `ADPM_SYNC_RST;
      o_input_serial_clock_oe_n <= 1'b1;
      o_output_word_sync_pin <= `ADPM_SYNC_RST;
      o_output_word_sync_oe_n <= 1'b1;
      o_in_word_sync <= 1'b0;
      o_in_serial_clock <= 1'b0;
      o_out_word_sync <= 1'b0;
      o_serial_data_inputs <= 3'h0;
      o_front_pair_out <= 1'b0;
      o_surround_pair_out <= 1'b0;
      o_center_sub_out <= 1'b0;
      o_port_g_or_spdif_out <= 1'b0;
    end else begin
      o_input_word_sync_pin <= i_core_word_sync;
      o_input_serial_clock_pin <= i_core_serial_clock;
      o_input_word_sync_oe_n <= ~i_serial_master;
      o_input_serial_clock_oe_n <= ~i_serial_master;
      o_in_word_sync <= i_serial_master ? i_core_word_sync : ws_s;
      o_in_serial_clock <= i_serial_master ? i_core_serial_clock : sck_s;
      o_serial_data_inputs <= sdi_s;
      o_output_word_sync_pin <= i_core_out_word_sync;
      o_output_word_sync_oe_n <= ~i_out_master;
      o_out_word_sync <= i_out_master ? i_core_out_word_sync : ows_s;
      o_front_pair_out <= i_front_pair_data;
      o_surround_pair_out <= i_surround_pair_data;
      o_center_sub_out <= i_center_sub_data;
      // S/PDIF needs its own master timing, so it is only selectable as master.
      o_port_g_or_spdif_out <= (i_spdif_select & i_out_master) ? i_spdif_tx_data :
        i_port_g_data;
    end
  end

  // Dedicated general purpose roles; data request is active low.
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mute <= 1'b0;
      o_data_request_out <= 1'b1;
      o_io_error_out <= 1'b0;
    end else begin
      o_mute <= mute_s;
      o_data_request_out <= ~i_data_request;
      o_io_error_out <= i_io_error;
    end
  end
endmodule

/* inc/adpm_defs.vh */
// Purpose: Constants for the audio processor pin configuration multiplexer.
// Assumes: One 125 MHz clock, asynchronous active-low reset.
// Notes: Straps are sampled on the third edge after reset release and frozen from then on.
// How it works
// - Memory/parallel select strap sampled at reset chooses parallel port role.
// - Memory mode drives 20-bit address and all 32 data lines both ways.
// - Parallel mode turns data line 14 into a driven ready output.
// - Parallel mode takes data line 13 as command/data select input.
// - Parallel mode takes data line 12 as an error input.
// - Parallel mode uses lines 11..4 as byte lane; others memory only.
// - Chip select, read, write strobes are outputs in memory mode, inputs otherwise.
// - Host byte traffic is blocked while the port serves external memory.
// - Input word sync and serial clock driven as master, received as slave.
// - Output word sync driven as master, received as slave.
// - Port B data level at reset selects four-wire or two-wire host link.
// - Port C and D data levels at reset set slave address bits 0, 1.
// - Port G data level at reset sets serial clock polarity.
// - Port G pin carries port G data or S/PDIF output, transmitter master only.
// - Ports B, C, D carry front, surround, center/sub channel pairs.
// - Up to eight DAC channels on ports B, C, D, G, master or slave.
// - Serial inputs A, E, F share one input word sync and clock.
// - Port A is slave or data-driven master using the data request output.
// - Three general pins become mute input, data request and error outputs.
// - Separate core and audio clocks let audio rates stay independent of input.
// - Host serial input and slave select at reset set address bits 5, 4.
`ifndef ADPM_DEFS_VH
`define ADPM_DEFS_VH
`define ADPM_ADDR_W 20
`define ADPM_DATA_W 32
`define ADPM_LANE_LO 4
`define ADPM_LANE_HI 11
`define ADPM_BIT_ERR 12
`define ADPM_BIT_CD 13
`define ADPM_BIT_RDY 14
`define ADPM_ADDR_BITS 6
`define ADPM_ADDR_RST 6'h00
`define ADPM_SYNC_RST 1'b0
`endif

/* verilog/adpm_sync2.v */
// Purpose: Two-flop synchroniser for one pin level.
// Assumes: Pin is asynchronous to i_clk.
// Notes: First stage is read only by the second stage.
`timescale 1ns/10ps
module adpm_sync2 (
  input wire i_clk,
  input wire i_rstn,
  input wire i_d,
  output reg o_q
);
  reg meta_r;
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= 1'b0;
      o_q <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule

/* tb/adpm_mon_monitor.sv */
// Purpose: Port-level checker for the pin configuration multiplexer.
// Assumes: Straps latch on the third edge after reset release; muxed outputs follow.
// Notes: Checks start at the sixth sampled edge after release, when the mux is live.
`timescale 1ns/10ps
module adpm_mon (
  input wire logic i_clk, i_rstn, i_host_ready, o_strobe_oe_n, o_host_cs, o_host_cmd_sel,
  input wire logic i_serial_master, i_core_word_sync, o_input_word_sync_oe_n, o_in_word_sync,
  input wire logic i_out_master, o_output_word_sync_oe_n, i_spdif_select, i_spdif_tx_data,
  input wire logic i_port_g_data, o_port_g_or_spdif_out, i_data_request, o_data_request_out,
  input wire logic o_parallel_mode,
  input wire logic [31:0] i_pd_pin, o_pd_pin, o_pd_oe_n,
  input wire logic [19:0] o_pa_pin, i_mem_addr,
  input wire logic [7:0] o_host_byte_lane_rx,
  input wire logic [5:0] o_two_wire_slave_addr
);
  logic [2:0] cnt_r;
  wire live = cnt_r == 3'h5;
  always @(posedge i_clk or negedge i_rstn)
    if (!i_rstn) cnt_r <= 3'h0;
    else if (!live) cnt_r <= cnt_r + 3'h1;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_ready_out: assert property (live && o_parallel_mode |->
    !o_pd_oe_n[14] && o_pd_pin[14] == $past(i_host_ready)) else $error("ready pin wrong");
  a_mem_addr: assert property (live && !o_parallel_mode |->
    o_pa_pin == $past(i_mem_addr) && !o_strobe_oe_n) else $error("memory side wrong");
  a_par_quiet: assert property (live && o_parallel_mode |-> o_strobe_oe_n &&
    o_pa_pin == 20'h0 && (&o_pd_oe_n[31:15]) && (&o_pd_oe_n[3:0])) else $error("lines driven");
  a_mem_host_idle: assert property (live && !o_parallel_mode |->
    o_host_cs && o_host_byte_lane_rx == 8'h00 && !o_host_cmd_sel) else $error("host not idle");
  a_lane_in: assert property (live && o_parallel_mode |->
    o_host_byte_lane_rx == 8'($past(i_pd_pin, 3) >> 4) &&
    o_host_cmd_sel == |($past(i_pd_pin, 3) & 32'h0000_2000)) else $error("lane input wrong");
  a_in_master: assert property (live |-> o_input_word_sync_oe_n == !$past(i_serial_master) &&
    (!$past(i_serial_master) || o_in_word_sync == $past(i_core_word_sync)))
    else $error("input sync role wrong");
  a_out_master: assert property (live |->
    o_output_word_sync_oe_n == !$past(i_out_master)) else $error("output sync role wrong");
  a_spdif_mux: assert property (live |-> o_port_g_or_spdif_out ==
    ($past(i_spdif_select) && $past(i_out_master) ? $past(i_spdif_tx_data) : $past(i_port_g_data)))
    else $error("port g source wrong");
  a_data_request_out_inv: assert property (live |->
    o_data_request_out == !$past(i_data_request)) else $error("data request wrong");
  a_straps_hold: assert property (live |-> $stable(o_parallel_mode) &&
    $stable(o_two_wire_slave_addr) && o_two_wire_slave_addr[3:2] == 2'h0) else $error("strap moved");
  c_par: cover property (live && o_parallel_mode);
  c_mem: cover property (live && !o_parallel_mode);
  c_spdif: cover property (live && $past(i_spdif_select) && $past(i_out_master));
endmodule
bind adpm_pin_mux adpm_mon u_mon (.i_clk(i_clk), .i_rstn(i_rstn), .i_host_ready(i_host_ready),
  .o_strobe_oe_n(o_strobe_oe_n), .o_host_cs(o_host_cs), .o_host_cmd_sel(o_host_cmd_sel),
  .i_serial_master(i_serial_master), .i_core_word_sync(i_core_word_sync),
  .o_input_word_sync_oe_n(o_input_word_sync_oe_n), .o_in_word_sync(o_in_word_sync),
  .i_out_master(i_out_master), .o_output_word_sync_oe_n(o_output_word_sync_oe_n),
  .i_spdif_select(i_spdif_select), .i_spdif_tx_data(i_spdif_tx_data),
  .i_port_g_data(i_port_g_data), .o_port_g_or_spdif_out(o_port_g_or_spdif_out),
  .i_data_request(i_data_request), .o_data_request_out(o_data_request_out),
  .o_parallel_mode(o_parallel_mode), .i_pd_pin(i_pd_pin), .o_pd_pin(o_pd_pin),
  .o_pd_oe_n(o_pd_oe_n), .o_pa_pin(o_pa_pin), .i_mem_addr(i_mem_addr),
  .o_host_byte_lane_rx(o_host_byte_lane_rx), .o_two_wire_slave_addr(o_two_wire_slave_addr));

/* tb/adpm_ext_party.sv */
// Purpose: External party on the parallel port: a byte host or a memory.
// Assumes: Bits 31:0 are data lines, 34:32 chip select, read and write.
// Notes: A line nobody drives shows the inverse of its last level.
`timescale 1ns/10ps
module adpm_ext_party (
  input wire logic i_clk,
  input wire logic [34:0] i_dev_d,
  input wire logic [34:0] i_dev_oe_n,
  input wire logic [34:0] i_ext_oe,
  input wire logic [34:0] i_ext_d,
  output logic [34:0] o_pad
);
  logic [34:0] last_r = 35'h0;
  always @(posedge i_clk) last_r <= o_pad;
  always_comb begin
    for (int i = 0; i < 35; i++) begin
      o_pad[i] = !i_dev_oe_n[i] ? i_dev_d[i] : (i_ext_oe[i] ? i_ext_d[i] : !last_r[i]);
    end
  end
endmodule

/* tb/testbench.sv */
// Purpose: Self-checking bench for the pin configuration multiplexer.
// Assumes: 125 MHz clock, straps held steady across reset release.
// Notes: Latency is checked by the bound monitor; scenarios wait four or five edges.
`timescale 1ns/10ps
module testbench;
  logic i_clk = 1'h0, i_rstn = 1'h0, i_mem_drive = 1'h0, i_mem_cs = 1'h1, i_mem_rd = 1'h1;
  logic i_mem_wr = 1'h1, i_host_byte_lane_drive = 1'h0, i_host_ready = 1'h0;
  logic i_serial_master = 1'h0, i_out_master = 1'h0, i_core_word_sync = 1'h0;
  logic i_core_serial_clock = 1'h0, i_core_out_word_sync = 1'h0, i_input_word_sync_pin = 1'h0;
  logic i_input_serial_clock_pin = 1'h0, i_output_word_sync_pin = 1'h0, i_front_pair_data = 1'h0;
  logic i_surround_pair_data = 1'h0, i_center_sub_data = 1'h0, i_port_g_data = 1'h0;
  logic i_spdif_tx_data = 1'h0, i_spdif_select = 1'h0, i_mute_pin = 1'h0;
  logic i_data_request = 1'h0, i_io_error = 1'h0;
  logic [19:0] i_mem_addr = 20'h0;
  logic [31:0] i_mem_wdata = 32'h0;
  logic [7:0] i_host_byte_lane_tx = 8'h0;
  logic [2:0] i_serial_data_inputs = 3'h0;
  logic [6:0] strap = 7'h0;
  logic [34:0] ext_oe = 35'h0, ext_d = 35'h0;
  int n_fail = 0, num_checks = 0, cyc = 0;
  wire [34:0] pad;
  wire [31:0] i_pd_pin = pad[31:0];
  wire i_cs_pin = pad[34], i_rd_pin = pad[33], i_wr_pin = pad[32];
  wire i_pm_sel_pin = strap[6], i_front_pair_pin_in = strap[5], i_surround_pair_pin_in = strap[4];
  wire i_center_sub_pin_in = strap[3], i_port_g_pin_in = strap[2];
  wire i_host_si_pin = strap[1], i_host_ss_pin = strap[0];
  wire o_cs_pin, o_rd_pin, o_wr_pin, o_strobe_oe_n, o_host_cmd_sel, o_host_err, o_host_cs;
  wire o_host_rd, o_host_wr, o_input_word_sync_pin, o_input_word_sync_oe_n, o_in_word_sync;
  wire o_input_serial_clock_pin, o_input_serial_clock_oe_n, o_output_word_sync_pin;
  wire o_output_word_sync_oe_n, o_in_serial_clock, o_out_word_sync, o_front_pair_out;
  wire o_surround_pair_out, o_center_sub_out, o_port_g_or_spdif_out, o_mute, o_io_error_out;
  wire o_data_request_out, o_parallel_mode, o_two_wire_host_link, o_serial_clock_polarity;
  wire [31:0] o_pd_pin, o_pd_oe_n, o_mem_rdata;
  wire [19:0] o_pa_pin;
  wire [7:0] o_host_byte_lane_rx;
  wire [2:0] o_serial_data_inputs;
  wire [5:0] o_two_wire_slave_addr;
  adpm_pin_mux DUT (.*);
  adpm_ext_party u_ext (.i_clk(i_clk), .i_dev_d({o_cs_pin, o_rd_pin, o_wr_pin, o_pd_pin}),
    .i_dev_oe_n({{3{o_strobe_oe_n}}, o_pd_oe_n}), .i_ext_oe(ext_oe), .i_ext_d(ext_d), .o_pad(pad));
  always #4 i_clk = ~i_clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic do_reset(input logic [6:0] s);
    @(posedge i_clk);
    i_rstn <= 1'h0;
    strap <= s;
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'h1;
    tick(5);
  endtask
  task automatic t_straps;
    logic [6:0] s;
    for (int k = 0; k < 2; k++) begin
      s = k ? 7'h2b : 7'h54;
      do_reset(s);
      chk(o_parallel_mode, s[6]);
      chk(o_two_wire_host_link, s[5]);
      chk(o_two_wire_slave_addr, {s[1], s[0], 2'h0, s[3], s[4]});
      chk(o_serial_clock_polarity, s[2]);
      @(posedge i_clk);
      strap <= ~s;
      tick(4);
      chk({o_parallel_mode, o_two_wire_slave_addr}, {s[6], s[1], s[0], 2'h0, s[3], s[4]});
    end
  endtask
  task automatic t_memory;
    @(posedge i_clk);
    i_mem_addr <= 20'habcde;
    i_mem_wdata <= 32'h5a5a_c3c3;
    i_mem_drive <= 1'h1;
    i_mem_cs <= 1'h0;
    i_host_ready <= 1'h1;
    tick(4);
    chk({o_pd_pin, o_pd_oe_n}, {32'h5a5a_c3c3, 32'h0});
    chk({o_cs_pin, o_rd_pin, o_wr_pin, o_strobe_oe_n}, 4'h6);
    chk(o_pa_pin, 20'habcde);
    chk({o_host_cs, o_host_rd, o_host_wr}, 3'h7);
    @(posedge i_clk);
    i_mem_drive <= 1'h0;
    ext_oe <= 35'h0_ffff_ffff;
    ext_d <= 35'h0_1234_5678;
    tick(5);
    chk(o_mem_rdata, 32'h1234_5678);
  endtask
  task automatic t_parallel;
    @(posedge i_clk);
    ext_oe <= 35'h7_0000_3ff0;
    ext_d <= 35'h3_0000_2a50;
    i_host_ready <= 1'h0;
    tick(4);
    chk({o_host_byte_lane_rx, o_host_cmd_sel, o_host_err}, 10'h296);
    chk({o_host_cs, o_host_rd, o_host_wr, o_strobe_oe_n}, 4'h7);
    chk({o_pd_pin[14], o_pd_oe_n[14], o_mem_rdata}, 34'h0);
    @(posedge i_clk);
    ext_oe <= 35'h7_0000_3000;
    ext_d <= 35'h7_0000_1000;
    i_host_ready <= 1'h1;
    i_host_byte_lane_drive <= 1'h1;
    i_host_byte_lane_tx <= 8'h3c;
    tick(4);
    chk({o_host_cmd_sel, o_host_err, o_pd_pin[14], o_pd_oe_n[14]}, 4'h6);
    chk({o_pd_pin[11:4], o_pd_oe_n[11:4]}, 16'h3c00);
  endtask
  task automatic t_serial;
    for (int m = 0; m < 8; m++) begin
      @(posedge i_clk);
      {i_serial_master, i_out_master, i_spdif_select} <= m[2:0];
      i_core_word_sync <= 1'h1;
      i_core_serial_clock <= 1'h1;
      i_core_out_word_sync <= 1'h1;
      i_spdif_tx_data <= 1'h1;
      tick(4);
      chk({o_input_word_sync_pin, o_input_serial_clock_pin, o_output_word_sync_pin}, 3'h7);
      chk({o_in_serial_clock, o_out_word_sync}, {m[2], m[1]});
      chk({o_input_word_sync_oe_n, o_input_serial_clock_oe_n}, {2{!m[2]}});
      chk(o_in_word_sync, m[2]);
      chk(o_output_word_sync_oe_n, !m[1]);
      chk(o_port_g_or_spdif_out, m[1] & m[0]);
    end
    @(posedge i_clk);
    {i_front_pair_data, i_center_sub_data, i_port_g_data, i_out_master} <= 4'he;
    {i_serial_data_inputs, i_data_request, i_mute_pin, i_io_error} <= 6'h2f;
    tick(4);
    chk({o_front_pair_out, o_surround_pair_out, o_center_sub_out, o_port_g_or_spdif_out}, 4'hb);
    chk({o_serial_data_inputs, o_mute, o_data_request_out, o_io_error_out}, 6'h2d);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  initial begin
    t_straps;
    t_memory;
    do_reset(7'h54);
    t_parallel;
    t_serial;
    tally_and_finish;
  end
endmodule
